//--- shared/dlfd_params.svh
// Notes on behaviour
// - Mode 000 auto-detects single, dual or replicate; 100 auto-detects single or replicate.
// - Mode 001 forces single link with second port off; 011 forces dual link.
// - Mode 101 forces independent two-by-two; 111 forces splitter, half stream per port.
// - Mode field loads from strap pin a after reset, giving 000 or 111.
// - Swap-correction disable bit 7 stops auto swap correction and unlocks swap writes.
// - Force-link-ready bit 6 reports link ready without back-channel detection.
// - Force-clock-detect bit 5 reports a valid input clock whatever the detector says.
// - Clock stable after frequency holds 40 us, 80 us, 320 us or 1.28 ms.
// - New frequency captured only when it differs by more than hysteresis MHz; reset 7.
// - In two-by-two mode the per-port control fields address the selected port.
// - Swap bit shows the automatic swap state; writes work only with correction disabled.
`ifndef DLFD_PARAMS_SVH
`define DLFD_PARAMS_SVH
// Registers sit one to a word, so the byte address is four times the register index.
`define DLFD_IDX_PORT_SEL    7'h50
`define DLFD_IDX_STATUS      7'h54
`define DLFD_IDX_CTL_ONE     7'h5B
`define DLFD_IDX_CTL_TWO     7'h5C
`define DLFD_OFF_PORT_SEL    {`DLFD_IDX_PORT_SEL, 2'b00}
`define DLFD_OFF_STATUS      {`DLFD_IDX_STATUS, 2'b00}
`define DLFD_OFF_CTL_ONE     {`DLFD_IDX_CTL_ONE, 2'b00}
`define DLFD_OFF_CTL_TWO     {`DLFD_IDX_CTL_TWO, 2'b00}
`define DLFD_BIT_SWAP        6
`define DLFD_BIT_ALIGN       3
`define DLFD_BIT_DIS_SWAP    7
`define DLFD_BIT_FRC_RDY     6
`define DLFD_BIT_FRC_CLK     5
`define DLFD_CTL_TWO_RST     8'h07
`define DLFD_HYST_RST        3'h7
`define DLFD_CLK_PERIOD_NS   40
`define DLFD_STBL_T0_NS      40000
`define DLFD_STBL_T1_NS      80000
`define DLFD_STBL_T2_NS      320000
`define DLFD_STBL_T3_NS      1280000
`define DLFD_STBL_C0         (`DLFD_STBL_T0_NS / `DLFD_CLK_PERIOD_NS)
`define DLFD_STBL_C1         (`DLFD_STBL_T1_NS / `DLFD_CLK_PERIOD_NS)
`define DLFD_STBL_C2         (`DLFD_STBL_T2_NS / `DLFD_CLK_PERIOD_NS)
`define DLFD_STBL_C3         (`DLFD_STBL_T3_NS / `DLFD_CLK_PERIOD_NS)
`endif

//--- shared/dlfd_pkg.sv
`default_nettype none
package dlfd_pkg;
  // Codes of the transmit link mode field.
  typedef enum logic [2:0] {
    TXM_AUTO     = 3'b000,
    TXM_SINGLE   = 3'b001,
    TXM_RSVD_A   = 3'b010,
    TXM_DUAL     = 3'b011,
    TXM_AUTO_ND  = 3'b100,
    TXM_INDEP    = 3'b101,
    TXM_RSVD_B   = 3'b110,
    TXM_SPLIT    = 3'b111
  } dlfd_txmode_e;
  // Operating mode the links actually run in.
  typedef enum logic [2:0] {
    LM_SINGLE = 3'b000,
    LM_DUAL   = 3'b001,
    LM_REPL   = 3'b010,
    LM_INDEP  = 3'b011,
    LM_SPLIT  = 3'b100
  } dlfd_linkmode_e;
endpackage
`default_nettype wire

//--- verilog/dlfd_freq_mon.sv
`timescale 1ns/1ps
`default_nettype none
module dlfd_freq_mon #(
  parameter int C0 = 1000,
  parameter int C1 = 2000,
  parameter int C2 = 8000,
  parameter int C3 = 32000
) (
  input  wire logic       clk_i,      // System clock.
  input  wire logic       rst_n_i,    // Synchronous reset, active low.
  input  wire logic [7:0] meas_i,     // Measured frequency in MHz.
  input  wire logic       meas_vld_i, // Measurement strobe.
  input  wire logic [2:0] hyst_i,     // Hysteresis in MHz.
  input  wire logic [1:0] thr_sel_i,  // Stability time select.
  output logic      [7:0] freq_o,     // Stored frequency.
  output logic            stable_o    // Frequency stable.
);
  logic [7:0]  freq_q;
  logic [15:0] cnt_q;
  logic [15:0] limit;
  logic [7:0]  diff;
  logic        capture;
  logic        stable_q;

  // Absolute difference between the new and the stored value.
  always_comb
  begin
    diff    = (meas_i > freq_q) ? meas_i - freq_q : freq_q - meas_i;
    capture = meas_vld_i && (diff > {5'h00, hyst_i});
    case (thr_sel_i)
      2'b00:   limit = 16'(C0);
      2'b01:   limit = 16'(C1);
      2'b10:   limit = 16'(C2);
      default: limit = 16'(C3);
    endcase
  end

  // Stored value moves only on a capture, so small jitter never resets the timer.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      freq_q <= 8'h00;
    else if (capture)
      freq_q <= meas_i;
  end

  // Stability timer; a capture restarts it and drops the stable flag.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      cnt_q    <= 16'h0000;
      stable_q <= 1'b0;
    end
    else if (capture)
    begin
      cnt_q    <= 16'h0000;
      stable_q <= 1'b0;
    end
    else if (!stable_q)
    begin
      if (cnt_q + 16'h0001 >= limit)
        stable_q <= 1'b1;
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  assign freq_o   = freq_q;
  assign stable_o = stable_q;

  restart_clears_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    capture |-> ##1 !stable_o [*8])
    else $error("stable seen right after a capture");
  hyst_holds_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    meas_vld_i && diff <= {5'h00, hyst_i} |=> freq_o == $past(freq_o))
    else $error("frequency captured inside hysteresis");
endmodule
`default_nettype wire

//--- verilog/dlfd_pixel_split.sv
`timescale 1ns/1ps
`default_nettype none
module dlfd_pixel_split #(
  parameter int DW       = 24,
  parameter int HALF_PIX = 960
) (
  input  wire logic          clk_i,   // System clock.
  input  wire logic          rst_n_i, // Synchronous reset, active low.
  input  wire logic [2:0]    mode_i,  // Effective link mode.
  input  wire logic          align_i, // Pixel parity alignment.
  input  wire logic          swap_i,  // Exchange the two links.
  input  wire logic          de_i,    // Data enable.
  input  wire logic [DW-1:0] pix_i,   // Pixel data.
  output logic [DW-1:0]      l0_o,    // Primary link data.
  output logic               l0_vld_o,// Primary link valid.
  output logic [DW-1:0]      l1_o,    // Secondary link data.
  output logic               l1_vld_o // Secondary link valid.
);
  logic        de_q;
  logic        par_q;
  logic        sel;
  logic        r0;
  logic        r1;
  logic [15:0] pcnt_q;
  logic        line_start;

  assign line_start = de_i && !de_q;

  // Pick which link takes this pixel.
  always_comb
  begin
    sel = align_i ? (line_start ? 1'b0 : par_q) : par_q;
    r0  = 1'b0;
    r1  = 1'b0;
    case (dlfd_pkg::dlfd_linkmode_e'(mode_i))
      dlfd_pkg::LM_SINGLE: r0 = de_i;
      dlfd_pkg::LM_DUAL:
      begin
        r0 = de_i && !sel;
        r1 = de_i && sel;
      end
      dlfd_pkg::LM_SPLIT:
      begin
        r0 = de_i && (line_start || pcnt_q < 16'(HALF_PIX));
        r1 = de_i && !(line_start || pcnt_q < 16'(HALF_PIX));
      end
      default:
      begin
        r0 = de_i;
        r1 = de_i;
      end
    endcase
  end

  // Parity and in-line pixel count.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      de_q   <= 1'b0;
      par_q  <= 1'b0;
      pcnt_q <= 16'h0000;
    end
    else
    begin
      de_q <= de_i;
      if (de_i)
      begin
        par_q  <= !sel;
        pcnt_q <= line_start ? 16'h0001 : pcnt_q + 16'h0001;
      end
    end
  end

  // Registered link outputs; the swap lets a crossed cable pair be undone here.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      l0_o     <= '0;
      l1_o     <= '0;
      l0_vld_o <= 1'b0;
      l1_vld_o <= 1'b0;
    end
    else
    begin
      l0_o     <= pix_i;
      l1_o     <= pix_i;
      l0_vld_o <= swap_i ? r1 : r0;
      l1_vld_o <= swap_i ? r0 : r1;
    end
  end

  first_pix_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    mode_i == 3'(dlfd_pkg::LM_DUAL) && align_i && !swap_i && line_start
    |=> l0_vld_o && !l1_vld_o ##1 (!de_q || (l1_vld_o && !l0_vld_o)))
    else $error("odd pixel not on primary link");
endmodule
`default_nettype wire

//--- verilog/dlfd_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "dlfd_params.svh"
module dlfd_top #(
  parameter int DW       = 24,
  parameter int HALF_PIX = 960,
  parameter int STBL_C2  = `DLFD_STBL_C2,
  parameter int STBL_C3  = `DLFD_STBL_C3
) (
  input  wire logic          SYS_CLK_I,       // System clock, 25 MHz.
  input  wire logic          RESETN_I,        // Synchronous reset, active low.
  input  wire logic          PSEL_I,          // APB select.
  input  wire logic          PENABLE_I,       // APB enable.
  input  wire logic          PWRITE_I,        // APB direction.
  input  wire logic [8:0]    PADDR_I,         // APB byte address.
  input  wire logic [31:0]   PWDATA_I,        // APB write data.
  output logic      [31:0]   PRDATA_O,        // APB read data.
  output logic               PREADY_O,        // APB ready.
  output logic               PSLVERR_O,       // APB error.
  input  wire logic          MODE_STRAP_A_I,  // Mode strap pin a.
  input  wire logic [1:0]    RX_PRESENT_I,    // Receiver seen per port.
  input  wire logic          RX_DUAL_CAP_I,   // Receiver can do dual.
  input  wire logic [1:0]    LINK_DETECT_I,   // Back-channel detect per port.
  input  wire logic          SWAP_DETECT_I,   // Swapped cabling seen.
  input  wire logic [1:0]    CLK_DETECT_I,    // Clock detector per port.
  input  wire logic [15:0]   FREQ_MEAS_I,     // Measured MHz, port 1 high.
  input  wire logic [1:0]    FREQ_VALID_I,    // Measurement strobes.
  input  wire logic          PIX_DE_I,        // Pixel data enable.
  input  wire logic [DW-1:0] PIX_DATA_I,      // Pixel data.
  output logic      [DW-1:0] LINK0_DATA_O,    // Primary link data.
  output logic               LINK0_VALID_O,   // Primary link valid.
  output logic      [DW-1:0] LINK1_DATA_O,    // Secondary link data.
  output logic               LINK1_VALID_O,   // Secondary link valid.
  output logic      [2:0]    LINK_MODE_O,     // Effective link mode.
  output logic               LINK_SWAP_O,     // Swap state.
  output logic      [1:0]    LINK_READY_O,    // Link ready per port.
  output logic      [1:0]    CLK_PRESENT_O,   // Clock valid per port.
  output logic      [1:0]    FREQ_STABLE_O    // Frequency stable per port.
);

  ////////////////////////////////////////////////////////////////////////////
  // Register state.

  logic                         strap_pend_q;
  dlfd_pkg::dlfd_txmode_e       txmode_q;
  logic                         align_q;
  logic                         swap_q;
  logic                         dis_swap_q;
  logic                         port_sel_q;
  logic [1:0]                   frc_rdy_q;
  logic [1:0]                   frc_clk_q;
  logic [1:0]                   thr_q [2];
  logic [2:0]                   hyst_q [2];
  dlfd_pkg::dlfd_linkmode_e     lmode_q;
  logic [31:0]                  prdata_q;
  logic [7:0]                   freq [2];
  logic [1:0]                   stable;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode. The slave answers with no wait states.

  logic wr_en;
  logic setup;
  logic hit;
  logic wr_one;
  logic wr_two;
  logic wr_psel;
  logic indep;
  logic rp;

  assign setup   = PSEL_I && !PENABLE_I;
  assign wr_en   = PSEL_I && PENABLE_I && PWRITE_I;
  assign hit     = PADDR_I == `DLFD_OFF_PORT_SEL || PADDR_I == `DLFD_OFF_STATUS
                || PADDR_I == `DLFD_OFF_CTL_ONE || PADDR_I == `DLFD_OFF_CTL_TWO;
  assign wr_one  = wr_en && PADDR_I == `DLFD_OFF_CTL_ONE;
  assign wr_two  = wr_en && PADDR_I == `DLFD_OFF_CTL_TWO;
  assign wr_psel = wr_en && PADDR_I == `DLFD_OFF_PORT_SEL;
  assign indep   = lmode_q == dlfd_pkg::LM_INDEP;
  // Outside two-by-two mode both port copies are written and port 0 is read.
  assign rp      = indep && port_sel_q;

  assign PREADY_O  = 1'b1;
  assign PSLVERR_O = PSEL_I && PENABLE_I && !hit;
  assign PRDATA_O  = prdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Mode field and strap capture. The strap is caught on the first edge after
  // reset release, so the reset branch itself only loads constants.

  always_ff @(posedge SYS_CLK_I)
  begin
    if (!RESETN_I)
    begin
      strap_pend_q <= 1'b1;
      txmode_q     <= dlfd_pkg::TXM_AUTO;
      align_q      <= 1'b0;
    end
    else if (strap_pend_q)
    begin
      strap_pend_q <= 1'b0;
      txmode_q     <= MODE_STRAP_A_I ? dlfd_pkg::TXM_SPLIT : dlfd_pkg::TXM_AUTO;
    end
    else if (wr_one)
    begin
      // Reserved codes are stored as written; they run as single link.
      txmode_q <= dlfd_pkg::dlfd_txmode_e'(PWDATA_I[2:0]);
      align_q  <= PWDATA_I[`DLFD_BIT_ALIGN];
    end
  end

  // Swap state: automatic unless correction is disabled, then software owned.
  always_ff @(posedge SYS_CLK_I)
  begin
    if (!RESETN_I)
      swap_q <= 1'b0;
    else if (!dis_swap_q)
      swap_q <= SWAP_DETECT_I;
    else if (wr_one)
      swap_q <= PWDATA_I[`DLFD_BIT_SWAP];
  end

  // Shared disable bit and register-access port select.
  always_ff @(posedge SYS_CLK_I)
  begin
    if (!RESETN_I)
    begin
      dis_swap_q <= 1'(`DLFD_CTL_TWO_RST >> `DLFD_BIT_DIS_SWAP);
      port_sel_q <= 1'b0;
    end
    else
    begin
      if (wr_two)
        dis_swap_q <= PWDATA_I[`DLFD_BIT_DIS_SWAP];
      if (wr_psel)
        port_sel_q <= PWDATA_I[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-port control fields, clock monitors and indications.

  genvar p;
  generate
    for (p = 0; p < 2; p++)
    begin : g_port
      always_ff @(posedge SYS_CLK_I)
      begin
        if (!RESETN_I)
        begin
          frc_rdy_q[p] <= 1'b0;
          frc_clk_q[p] <= 1'b0;
          thr_q[p]     <= 2'b00;
          hyst_q[p]    <= `DLFD_HYST_RST;
        end
        else if (wr_two && (!indep || port_sel_q == 1'(p)))
        begin
          frc_rdy_q[p] <= PWDATA_I[`DLFD_BIT_FRC_RDY];
          frc_clk_q[p] <= PWDATA_I[`DLFD_BIT_FRC_CLK];
          thr_q[p]     <= PWDATA_I[4:3];
          hyst_q[p]    <= PWDATA_I[2:0];
        end
      end

      dlfd_freq_mon #(
        .C0 (`DLFD_STBL_C0),
        .C1 (`DLFD_STBL_C1),
        .C2 (STBL_C2),
        .C3 (STBL_C3)
      ) u_mon (
        .clk_i      (SYS_CLK_I),
        .rst_n_i    (RESETN_I),
        .meas_i     (FREQ_MEAS_I[8*p +: 8]),
        .meas_vld_i (FREQ_VALID_I[p]),
        .hyst_i     (hyst_q[p]),
        .thr_sel_i  (thr_q[p]),
        .freq_o     (freq[p]),
        .stable_o   (stable[p])
      );

      // Forcing bypasses back-channel detection and the clock detector.
      assign LINK_READY_O[p]  = frc_rdy_q[p] || LINK_DETECT_I[p];
      assign CLK_PRESENT_O[p] = frc_clk_q[p] || CLK_DETECT_I[p];
      assign FREQ_STABLE_O[p] = stable[p];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Effective link mode from the field and the attached receivers.

  always_ff @(posedge SYS_CLK_I)
  begin
    if (!RESETN_I)
      lmode_q <= dlfd_pkg::LM_SINGLE;
    else
    begin
      case (txmode_q)
        dlfd_pkg::TXM_AUTO:
          if (&RX_PRESENT_I)
            lmode_q <= RX_DUAL_CAP_I ? dlfd_pkg::LM_DUAL : dlfd_pkg::LM_REPL;
          else
            lmode_q <= dlfd_pkg::LM_SINGLE;
        dlfd_pkg::TXM_AUTO_ND:
          lmode_q <= (&RX_PRESENT_I) ? dlfd_pkg::LM_REPL : dlfd_pkg::LM_SINGLE;
        dlfd_pkg::TXM_SINGLE: lmode_q <= dlfd_pkg::LM_SINGLE;
        dlfd_pkg::TXM_DUAL:   lmode_q <= dlfd_pkg::LM_DUAL;
        // Software must gate the video inputs before choosing this mode.
        dlfd_pkg::TXM_INDEP:  lmode_q <= dlfd_pkg::LM_INDEP;
        dlfd_pkg::TXM_SPLIT:  lmode_q <= dlfd_pkg::LM_SPLIT;
        default:              lmode_q <= dlfd_pkg::LM_SINGLE;
      endcase
    end
  end

  assign LINK_MODE_O = lmode_q;
  assign LINK_SWAP_O = swap_q;

  ////////////////////////////////////////////////////////////////////////////
  // Read data is captured in the setup phase so it comes from a flip-flop.

  always_ff @(posedge SYS_CLK_I)
  begin
    if (!RESETN_I)
      prdata_q <= 32'h0000_0000;
    else if (setup && !PWRITE_I)
    begin
      case (PADDR_I)
        `DLFD_OFF_CTL_ONE:
          prdata_q <= {25'h0, swap_q, 2'b00, align_q, txmode_q};
        `DLFD_OFF_CTL_TWO:
          prdata_q <= {24'h0, dis_swap_q, frc_rdy_q[rp], frc_clk_q[rp],
                       thr_q[rp], hyst_q[rp]};
        `DLFD_OFF_PORT_SEL:
          prdata_q <= {31'h0, port_sel_q};
        `DLFD_OFF_STATUS:
          prdata_q <= {16'h0, freq[rp], 2'b00, lmode_q, stable[rp],
                       CLK_PRESENT_O[rp], LINK_READY_O[rp]};
        default:
          prdata_q <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pixel distribution over the two links.

  dlfd_pixel_split #(
    .DW       (DW),
    .HALF_PIX (HALF_PIX)
  ) u_split (
    .clk_i    (SYS_CLK_I),
    .rst_n_i  (RESETN_I),
    .mode_i   (lmode_q),
    .align_i  (align_q),
    .swap_i   (swap_q),
    .de_i     (PIX_DE_I),
    .pix_i    (PIX_DATA_I),
    .l0_o     (LINK0_DATA_O),
    .l0_vld_o (LINK0_VALID_O),
    .l1_o     (LINK1_DATA_O),
    .l1_vld_o (LINK1_VALID_O)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  strap_load_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
    $rose(RESETN_I) |=> txmode_q == ($past(MODE_STRAP_A_I) ? 3'b111 : 3'b000))
    else $error("mode field not loaded from strap");
  swap_auto_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
    !dis_swap_q |=> swap_q == $past(SWAP_DETECT_I))
    else $error("swap not following detector");
  swap_hold_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
    dis_swap_q && !wr_one |=> $stable(swap_q))
    else $error("swap moved while correction off");
  force_ready_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
    frc_rdy_q[0] |-> LINK_READY_O[0])
    else $error("forced link ready not shown");
  force_clock_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
    wr_two && PWDATA_I[5] && !indep |=> CLK_PRESENT_O == 2'b11)
    else $error("forced clock present not shown");
  forced_single_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
    txmode_q == dlfd_pkg::TXM_SINGLE [*2] |-> lmode_q == dlfd_pkg::LM_SINGLE)
    else $error("forced single not applied");
  auto_nodual_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
    txmode_q == dlfd_pkg::TXM_AUTO_ND |=> lmode_q != dlfd_pkg::LM_DUAL)
    else $error("dual chosen with dual excluded");
  bad_addr_a: assert property (@(posedge SYS_CLK_I) disable iff (!RESETN_I)
    PSEL_I && PENABLE_I && PADDR_I == 9'h000 |-> PSLVERR_O && PREADY_O)
    else $error("unmapped address not flagged");
endmodule
`default_nettype wire

//--- dv/dlfd_rx_model.sv
`timescale 1ns/1ps
`default_nettype none
// Far-end receiver pair: it announces itself and locks its back channel after a delay.
module dlfd_rx_model (
  input  wire logic       clk_i,      // System clock.
  input  wire logic       rst_n_i,    // Synchronous reset, active low.
  input  wire logic [1:0] attach_i,   // Receivers plugged in.
  input  wire logic       dual_i,     // Receivers can pair up.
  input  wire logic       swap_i,     // Cables crossed.
  input  wire logic [3:0] lock_dly_i, // Back-channel lock delay.
  output logic      [1:0] present_o,  // Receiver seen per port.
  output logic            dual_cap_o, // Dual capability.
  output logic      [1:0] detect_o,   // Back-channel detect.
  output logic            swap_o      // Swap seen.
);
  logic [3:0] cnt_q;
  // Presence and capability feed the automatic mode choice.
  assign present_o  = attach_i;
  assign dual_cap_o = dual_i;
  assign swap_o     = swap_i;
  assign detect_o   = (cnt_q == lock_dly_i) ? attach_i : 2'h0;
  // Lock restarts when all receivers go away, so a slow delay keeps detect low a while.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i || attach_i == 2'h0)
      cnt_q <= 4'h0;
    else if (cnt_q != lock_dly_i)
      cnt_q <= cnt_q + 4'h1;
  end
endmodule
`default_nettype wire

//--- dv/dual_link_mode_and_freq_detect_ctl_test.sv
`timescale 1ns/1ps
`default_nettype none
module dual_link_mode_and_freq_detect_ctl_test;
  logic SYS_CLK_I = 1'b0, RESETN_I = 1'b0, PSEL_I = 1'b0, PENABLE_I = 1'b0, PWRITE_I = 1'b0;
  logic PIX_DE_I = 1'b0, MODE_STRAP_A_I = 1'b1, alt = 1'b0, dcap = 1'b1, swp = 1'b0, rerr;
  logic PREADY_O, PSLVERR_O, LINK0_VALID_O, LINK1_VALID_O, LINK_SWAP_O;
  logic [8:0] PADDR_I = 9'h000;
  logic [31:0] PWDATA_I = 32'h0, PRDATA_O, rdat;
  logic [1:0] CLK_DETECT_I = 2'h0, FREQ_VALID_I = 2'h0, att = 2'h0;
  logic [1:0] LINK_READY_O, CLK_PRESENT_O, FREQ_STABLE_O;
  logic [15:0] FREQ_MEAS_I = 16'h0;
  logic [23:0] PIX_DATA_I = 24'h0, LINK0_DATA_O, LINK1_DATA_O, q0[$], q1[$], e0[$], e1[$];
  logic [2:0] LINK_MODE_O;
  logic [3:0] dly = 4'h1;
  wire logic [1:0] RX_PRESENT_I, LINK_DETECT_I;
  wire logic RX_DUAL_CAP_I, SWAP_DETECT_I;
  int err_total = 0, n_compared = 0;
  logic [2:0] codes[6] = '{3'h0, 3'h1, 3'h3, 3'h4, 3'h4, 3'h5};
  int lims[4] = '{1000, 2000, 20, 40};

  dlfd_top #(.HALF_PIX(2), .STBL_C2(20), .STBL_C3(40)) DUT (.SYS_CLK_I, .RESETN_I, .PSEL_I, .PENABLE_I, .PWRITE_I,
    .PADDR_I, .PWDATA_I, .PRDATA_O, .PREADY_O, .PSLVERR_O, .MODE_STRAP_A_I, .RX_PRESENT_I,
    .RX_DUAL_CAP_I, .LINK_DETECT_I, .SWAP_DETECT_I, .CLK_DETECT_I, .FREQ_MEAS_I, .FREQ_VALID_I,
    .PIX_DE_I, .PIX_DATA_I, .LINK0_DATA_O, .LINK0_VALID_O, .LINK1_DATA_O, .LINK1_VALID_O,
    .LINK_MODE_O, .LINK_SWAP_O, .LINK_READY_O, .CLK_PRESENT_O, .FREQ_STABLE_O);
  dlfd_rx_model far_end (.clk_i(SYS_CLK_I), .rst_n_i(RESETN_I), .attach_i(att), .dual_i(dcap),
    .swap_i(swp), .lock_dly_i(dly), .present_o(RX_PRESENT_I), .dual_cap_o(RX_DUAL_CAP_I),
    .detect_o(LINK_DETECT_I), .swap_o(SWAP_DETECT_I));

  // Free-running 25 MHz system clock.
  always #20 SYS_CLK_I = ~SYS_CLK_I;

  // Collect every pixel that leaves on either link.
  always @(posedge SYS_CLK_I)
  begin
    if (LINK0_VALID_O === 1'b1)
      q0.push_back(LINK0_DATA_O);
    if (LINK1_VALID_O === 1'b1)
      q1.push_back(LINK1_DATA_O);
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic results;
    if (err_total == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge SYS_CLK_I);
  endtask

  // One APB transfer; the request is held until pready is seen at a rising edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge SYS_CLK_I);
    PSEL_I <= 1'b1;
    PWRITE_I <= w;
    PADDR_I <= {a[6:0], 2'b00}; // Register index to byte address.
    PWDATA_I <= d;
    @(posedge SYS_CLK_I);
    PENABLE_I <= 1'b1;
    n = 0;
    do
    begin
      @(posedge SYS_CLK_I);
      n++;
    end
    while (PREADY_O !== 1'b1 && n < 50);
    if (n == 50)
    begin
      err_total++;
      results;
    end
    rdat = PRDATA_O;
    rerr = PSLVERR_O;
    PSEL_I <= 1'b0;
    PENABLE_I <= 1'b0;
  endtask

  // Expected effective mode from the requested code and the attached receivers.
  function automatic logic [2:0] exp_mode(input logic [2:0] m, input logic [1:0] at, input logic dc);
    case (m)
      3'h0: return (&at) ? (dc ? 3'h1 : 3'h2) : 3'h0;
      3'h4: return (&at) ? 3'h2 : 3'h0;
      3'h3: return 3'h1;
      3'h5: return 3'h3;
      3'h7: return 3'h4;
      default: return 3'h0;
    endcase
  endfunction

  // One line of pixels; al picks free alternation (0), pixel position (1) or half line (2).
  task automatic line(input int n, input int al);
    logic [23:0] v;
    for (int i = 0; i < n; i++)
    begin
      v = 24'($urandom);
      @(posedge SYS_CLK_I);
      PIX_DE_I <= 1'b1;
      PIX_DATA_I <= v;
      if ((al == 2) ? (i < 2) : ((al == 1) ? !i[0] : !alt))
        e0.push_back(v);
      else
        e1.push_back(v);
      alt = ~alt;
    end
    @(posedge SYS_CLK_I);
    PIX_DE_I <= 1'b0;
  endtask

  task automatic cmpq;
    tick(3);
    chk("link0 count", q0.size(), e0.size());
    chk("link1 count", q1.size(), e1.size());
    foreach (e0[i]) chk("link0 pixel", q0[i], e0[i]);
    foreach (e1[i]) chk("link1 pixel", q1[i], e1[i]);
    q0 = {};
    q1 = {};
    e0 = {};
    e1 = {};
  endtask

  task automatic strobe(input logic [7:0] v);
    @(posedge SYS_CLK_I);
    FREQ_MEAS_I <= {8'h00, v};
    FREQ_VALID_I <= 2'h1;
    @(posedge SYS_CLK_I);
    FREQ_VALID_I <= 2'h0;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence; video input stays idle while modes are switched.
  initial
  begin
    logic [2:0] e;
    int n;
    void'($urandom(32'hD5BF));
    codes[5] = 3'h7;
    codes[4] = 3'h5;
    repeat (16) @(posedge SYS_CLK_I);
    RESETN_I <= 1'b1;
    tick(3);
    apb(0, 8'h5C, 32'h0);
    chk("ctl two reset", rdat, 32'h7);
    chk("mapped no error", rerr, 1'b0);
    apb(0, 8'h5B, 32'h0);
    chk("strap mode", rdat[2:0], 3'h7);
    chk("strap link mode", LINK_MODE_O, 3'h4);
    apb(0, 8'h60, 32'h0);
    chk("unmapped error", rerr, 1'b1);
    for (int c = 0; c < 3; c++)
      foreach (codes[k])
      begin
        att <= (c == 2) ? 2'h1 : 2'h3;
        dcap <= (c == 0);
        apb(1, 8'h5B, {29'h0, codes[k]});
        e = exp_mode(codes[k], att, dcap);
        for (n = 0; n < 10 && LINK_MODE_O !== e; n++) tick(1);
        chk("link mode", LINK_MODE_O, e);
      end
    att <= 2'h0;
    apb(1, 8'h5B, 32'h5);
    apb(1, 8'h50, 32'h1);
    apb(1, 8'h5C, 32'h47);
    apb(1, 8'h50, 32'h0);
    apb(1, 8'h5C, 32'h27);
    tick(2);
    chk("ready per port", LINK_READY_O, 2'h2);
    chk("clock per port", CLK_PRESENT_O, 2'h1);
    apb(1, 8'h5B, 32'h3);
    apb(1, 8'h5C, 32'h67);
    tick(2);
    chk("forced ready", LINK_READY_O, 2'h3);
    chk("forced clock", CLK_PRESENT_O, 2'h3);
    apb(1, 8'h5C, 32'h7);
    CLK_DETECT_I <= 2'h2;
    att <= 2'h3;
    dly <= 4'($urandom_range(15, 1));
    tick(20);
    chk("detected ready", LINK_READY_O, 2'h3);
    chk("detected clock", CLK_PRESENT_O, 2'h2);
    line(3, 0);
    line(4, 0);
    cmpq;
    apb(1, 8'h5B, 32'hB);
    line(5, 1);
    line(4, 1);
    cmpq;
    apb(1, 8'h5B, 32'h7);
    line(4, 2);
    cmpq;
    swp <= 1'b1;
    tick(3);
    chk("auto swap", LINK_SWAP_O, 1'b1);
    apb(1, 8'h5B, 32'h3);
    tick(2);
    chk("swap write locked", LINK_SWAP_O, 1'b1);
    apb(1, 8'h5C, 32'h87);
    apb(1, 8'h5B, 32'h3);
    tick(2);
    chk("swap write open", LINK_SWAP_O, 1'b0);
    apb(0, 8'h5B, 32'h0);
    chk("swap readback", rdat[6], 1'b0);
    for (int t = 0; t < 4; t++)
    begin
      apb(1, 8'h5C, {27'h0, 2'(t), 3'h7});
      strobe(8'(40 + 30 * t));
      tick(1);
      chk("stable cleared", FREQ_STABLE_O[0], 1'b0);
      for (n = 1; n < lims[t] + 5 && FREQ_STABLE_O[0] !== 1'b1; n++) tick(1);
      chk("stability time", n >= lims[t] - 1 && n <= lims[t] + 1, 1'b1);
    end
    strobe(8'h82 + 8'($urandom_range(7)));
    tick(2);
    chk("within hysteresis", FREQ_STABLE_O[0], 1'b1);
    apb(0, 8'h54, 32'h0);
    chk("stored freq kept", rdat[15:8], 8'h82);
    strobe(8'h8A);
    tick(2);
    chk("outside hysteresis", FREQ_STABLE_O, 2'h2);
    apb(0, 8'h54, 32'h0);
    chk("stored freq new", rdat[15:8], 8'h8A);
    results;
  end
endmodule
`default_nettype wire
